// File: bral_core.sv
// Function
// - Register indirect mode joins the three pointer registers into a 10-bit RAM address.
// - Direct mode uses the whole 10-bit second instruction word as the RAM address.
// - Sixteen memory registers sit at RAM $040 to $04F for the memory register instructions.
// - A far jump, its variant or a far call loads all 14 PC bits from the immediate.
// - ROM is 32 pages of 256 words, the page being PC bits 12 to 8.
// - An in-page jump replaces PC bits 7 to 0 and keeps the page bits.
// - An in-page jump at the last word of a page applies to the incremented PC.
// - A zero-page call loads 6 bits into PC 5 to 0 and clears PC 13 to 6.
// - A table jump targets an address from the 4-bit immediate, accumulator and auxiliary.
// - A table fetch with word bit 8 set loads its low byte into accumulator and auxiliary.
// - A table fetch with word bit 9 set loads its low byte into both port output registers.
// - With both bits set all four destinations update in the same operation.
// - A table fetch leaves normal program counter sequencing unchanged.
`timescale 1ns/1ps
`default_nettype none
module bral_core
   import bral_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic step,
   input wire logic [2:0] op,
   input wire logic [13:0] imm,
   input wire logic [3:0] acc_in,
   input wire logic [3:0] aux_in,
   input wire logic [1:0] ram_mode,
   input wire logic [3:0] ptr_hi,
   input wire logic [3:0] ptr_mid,
   input wire logic [3:0] ptr_lo,
   input wire logic [9:0] direct_word,
   input wire logic [3:0] memreg_sel,
   input wire logic [9:0] rom_data,
   output logic [13:0] pc,
   output logic [13:0] rom_addr,
   output logic [9:0] ram_addr,
   output logic [3:0] acc_out,
   output logic [3:0] aux_out,
   output logic acc_we,
   output logic [3:0] port_one_output,
   output logic [3:0] port_two_output,
   output logic [4:0] page
);
   // Fetch state: a table fetch reads ROM in a second cycle.
   typedef enum logic [1:0]
   {
      BRAL_ST_RUN = 2'b01,
      BRAL_ST_FETCH = 2'b10
   } bral_st_t;

   typedef struct packed
   {
      bral_st_t st;
      logic [13:0] pc;
      logic [3:0] acc;
      logic [3:0] aux;
      logic acc_we;
      logic [3:0] p1;
      logic [3:0] p2;
   } bral_state_t;

   bral_state_t cur_r;
   bral_state_t cur_nxt;
   bral_tbl_if tbl ();
   logic [13:0] pc_inc;

   // Table address is built in its own unit so jump and fetch share it.
   bral_tbl_addr u_tbl
   (
      .bus(tbl.unit)
   );

   bral_ram_addr u_ram
   (
      .mode(ram_mode),
      .ptr_hi(ptr_hi),
      .ptr_mid(ptr_mid),
      .ptr_lo(ptr_lo),
      .direct_word(direct_word),
      .memreg_sel(memreg_sel),
      .ram_addr(ram_addr)
   );

   assign tbl.tbl_imm = imm[3:0];
   assign tbl.acc = acc_in;
   assign tbl.aux = aux_in;
   assign pc_inc = cur_r.pc + 14'h0001;

   // Next-state logic; the in-page jump uses the incremented page so a jump
   // at offset 255 lands in the next page rather than wrapping inside the old one.
   always_comb
   begin
      cur_nxt = cur_r;
      cur_nxt.acc_we = 1'b0;
      case (cur_r.st)
         BRAL_ST_RUN:
         begin
            if (step)
            begin
               case (op)
                  BRAL_OP_FAR: cur_nxt.pc = imm;
                  BRAL_OP_PAGE: cur_nxt.pc = {pc_inc[13:8], imm[7:0]};
                  BRAL_OP_ZPCALL: cur_nxt.pc = {8'h00, imm[5:0]};
                  BRAL_OP_TABLE: cur_nxt.pc = tbl.tbl_addr;
                  BRAL_OP_FETCH:
                  begin
                     cur_nxt.pc = pc_inc;
                     cur_nxt.st = BRAL_ST_FETCH;
                  end
                  default: cur_nxt.pc = pc_inc;
               endcase
            end
         end
         BRAL_ST_FETCH:
         begin
            // Both flags are tested independently, so both may update at once.
            if (rom_data[TBL_ACC_BIT])
            begin
               cur_nxt.acc = rom_data[7:4];
               cur_nxt.aux = rom_data[3:0];
               cur_nxt.acc_we = 1'b1;
            end
            if (rom_data[TBL_PORT_BIT])
            begin
               cur_nxt.p1 = rom_data[7:4];
               cur_nxt.p2 = rom_data[3:0];
            end
            cur_nxt.st = BRAL_ST_RUN;
         end
         default: cur_nxt.st = BRAL_ST_RUN;
      endcase
   end

   // State register.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cur_r.st <= BRAL_ST_RUN;
         cur_r.pc <= PC_RST;
         cur_r.acc <= NIB_RST;
         cur_r.aux <= NIB_RST;
         cur_r.acc_we <= 1'b0;
         cur_r.p1 <= NIB_RST;
         cur_r.p2 <= NIB_RST;
      end
      else
      begin
         cur_r <= cur_nxt;
      end
   end

   // During a fetch the ROM is pointed at the table word instead of the PC.
   assign rom_addr = (cur_r.st == BRAL_ST_FETCH) ? tbl.tbl_addr : cur_r.pc;
   assign pc = cur_r.pc;
   // Thirty-two pages need five bits, so the page number is cut to PC bits 12 to 8.
   assign page = cur_r.pc[12:8];
   assign acc_out = cur_r.acc;
   assign aux_out = cur_r.aux;
   assign acc_we = cur_r.acc_we;
   assign port_one_output = cur_r.p1;
   assign port_two_output = cur_r.p2;
endmodule
`default_nettype wire

// File: bral_pkg.sv
package bral_pkg;
   localparam int PC_W = 14;
   localparam int RAM_AW = 10;
   localparam int WORD_W = 10;
   localparam int NIB_W = 4;
   // Page geometry: 32 pages of 256 words.
   localparam int PAGE_CNT = 32;
   localparam int PAGE_WORDS = 256;
   localparam int PAGE_LSB_W = 8;
   localparam int ZP_W = 6;
   // Memory registers occupy all sixteen nibbles of this window.
   localparam logic [9:0] MEMREG_BASE = 10'h040;
   localparam logic [9:0] MEMREG_LAST = 10'h04f;
   // Table word flag bit positions.
   localparam int TBL_ACC_BIT = 8;
   localparam int TBL_PORT_BIT = 9;
   localparam logic [13:0] PC_RST = 14'h0000;
   localparam logic [3:0] NIB_RST = 4'h0;

   // Operation requested by the instruction decoder for the current word.
   typedef enum logic [2:0]
   {
      BRAL_OP_SEQ = 3'h0,
      BRAL_OP_FAR = 3'h1,
      BRAL_OP_PAGE = 3'h2,
      BRAL_OP_ZPCALL = 3'h3,
      BRAL_OP_TABLE = 3'h4,
      BRAL_OP_FETCH = 3'h5
   } bral_op_t;

   typedef enum logic [1:0]
   {
      BRAL_RAM_IND = 2'h0,
      BRAL_RAM_DIR = 2'h1,
      BRAL_RAM_MEMREG = 2'h2
   } bral_ram_mode_t;
endpackage

// File: bral_tbl_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the table address and its immediate, accumulator and auxiliary inputs between the sequencer and the table unit.
interface bral_tbl_if;
   logic [13:0] tbl_addr;
   logic [3:0] tbl_imm;
   logic [3:0] acc;
   logic [3:0] aux;
   modport unit (input tbl_imm, input acc, input aux, output tbl_addr);
   modport user (output tbl_imm, output acc, output aux, input tbl_addr);
endinterface
`default_nettype wire

// File: bral_ram_addr.sv
`timescale 1ns/1ps
`default_nettype none
module bral_ram_addr
   import bral_pkg::*;
(
   input wire logic [1:0] mode,
   input wire logic [3:0] ptr_hi,
   input wire logic [3:0] ptr_mid,
   input wire logic [3:0] ptr_lo,
   input wire logic [9:0] direct_word,
   input wire logic [3:0] memreg_sel,
   output logic [9:0] ram_addr
);
   // Address mux; the high pointer only contributes its low two bits to fill 10 bits.
   always_comb
   begin
      case (mode)
         BRAL_RAM_IND: ram_addr = {ptr_hi[1:0], ptr_mid, ptr_lo};
         BRAL_RAM_DIR: ram_addr = direct_word;
         BRAL_RAM_MEMREG: ram_addr = MEMREG_BASE | {6'h00, memreg_sel};
         default: ram_addr = {ptr_hi[1:0], ptr_mid, ptr_lo};
      endcase
   end
endmodule
`default_nettype wire

// File: bral_tbl_addr.sv
`timescale 1ns/1ps
`default_nettype none
module bral_tbl_addr
   import bral_pkg::*;
(
   bral_tbl_if.unit bus
);
   // Upper two bits are zero, so tables live in the low 4K words.
   assign bus.tbl_addr = {2'b00, bus.tbl_imm, bus.acc, bus.aux};
endmodule
`default_nettype wire

// File: bral_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module bral_rom_model
   import bral_pkg::*;
(
   input wire logic [13:0] rom_addr,
   output logic [9:0] rom_data
);
   // A fixed scramble of the address, so random table addresses hit every flag pair.
   assign rom_data = rom_addr[9:0] ^ {rom_addr[13:10], 6'h2a};
endmodule
`default_nettype wire

// File: bral_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bral_core_checker
   import bral_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic step,
   input wire logic [2:0] op,
   input wire logic [13:0] imm,
   input wire logic [3:0] acc_in,
   input wire logic [3:0] aux_in,
   input wire logic [1:0] ram_mode,
   input wire logic [3:0] ptr_hi,
   input wire logic [3:0] ptr_mid,
   input wire logic [3:0] ptr_lo,
   input wire logic [9:0] direct_word,
   input wire logic [3:0] memreg_sel,
   input wire logic [9:0] rom_data,
   input wire logic [13:0] pc,
   input wire logic [9:0] ram_addr,
   input wire logic [3:0] acc_out,
   input wire logic [3:0] aux_out,
   input wire logic [3:0] port_one_output,
   input wire logic [3:0] port_two_output
);
   logic fb_r;
   logic go;
   logic [13:0] nx, pg, zp, tb;
   logic [7:0] lb;
   // Words offered during the fetch cycle are ignored, so only accepted words count.
   assign go = step && !fb_r;
   assign nx = pc + 14'h1;
   assign pg = {nx[13:8], imm[7:0]};
   assign zp = {8'h00, imm[5:0]};
   assign tb = {2'h0, imm[3:0], acc_in, aux_in};
   assign lb = rom_data[7:0];
   // Tracks the fetch cycle that follows an accepted fetch word.
   always_ff @(posedge clk_sys)
   begin
      fb_r <= rst ? 1'b0 : (go && op == 3'h5);
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Address forming, program counter updates and table fetch loads, each tied to its cause.
   AST_IND: assert property (ram_mode == 2'h0 |-> ram_addr == {ptr_hi[1:0], ptr_mid, ptr_lo})
      else $error("indirect ram address wrong");
   AST_DIR: assert property (ram_mode == 2'h1 |-> ram_addr == direct_word)
      else $error("direct ram address wrong");
   AST_MREG: assert property (ram_mode == 2'h2 |-> ram_addr == (MEMREG_BASE | memreg_sel))
      else $error("memory register address wrong");
   AST_FAR: assert property (go && op == 3'h1 |=> pc == $past(imm))
      else $error("far jump target wrong");
   AST_PAGE: assert property (go && op == 3'h2 |=> pc == $past(pg))
      else $error("in-page jump target wrong");
   AST_ZP: assert property (go && op == 3'h3 |=> pc == $past(zp))
      else $error("zero-page call target wrong");
   AST_TBL: assert property (go && op == 3'h4 |=> pc == $past(tb))
      else $error("table jump target wrong");
   AST_SEQ: assert property (go && (op == 3'h0 || op == 3'h5) |=> pc == $past(nx))
      else $error("sequential advance wrong");
   AST_HOLD: assert property (fb_r |=> $stable(pc))
      else $error("pc moved during fetch cycle");
   AST_ACC: assert property (fb_r && rom_data[8] |=> {acc_out, aux_out} == $past(lb))
      else $error("fetch did not load acc and aux");
   AST_PORT: assert property (fb_r && rom_data[9] |=> {port_one_output, port_two_output} == $past(lb))
      else $error("fetch did not load port outputs");
   // Main scenarios seen at least once.
   cover property (fb_r && rom_data[9:8] == 2'h3);
   cover property (go && op == 3'h2 && pc[7:0] == 8'hff);
   cover property (go && op == 3'h4);
endmodule
bind bral_core bral_core_checker bral_core_checker_i (.*);
`default_nettype wire

// File: bral_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module bral_core_bench;
   import bral_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, step = 1'b0, acc_we;
   logic [2:0] op = 3'h0;
   logic [13:0] imm = 14'h0000, pc, rom_addr, ep = 14'h0000, nx, ta;
   logic [3:0] acc_in = 4'h0, aux_in = 4'h0, ptr_hi = 4'h0, ptr_mid = 4'h0, ptr_lo = 4'h0;
   logic [3:0] memreg_sel = 4'h0, acc_out, aux_out, port_one_output, port_two_output;
   logic [3:0] ea = 4'h0, eb = 4'h0, e1 = 4'h0, e2 = 4'h0;
   logic [1:0] ram_mode = 2'h0;
   logic [9:0] direct_word = 10'h000, rom_data, ram_addr, d;
   logic [4:0] page;
   logic [63:0] r;
   int seed = 32'h2d95, r2, n_fail = 0, total_checks = 0;
   always #10 clk_sys = ~clk_sys;
   bral_core bral_core_i (.*);
   bral_rom_model bral_rom_model_i (.*);
   // One instruction word at a falling edge; a fetch drops step and holds its other inputs through the fetch cycle.
   task automatic run(input logic s, input logic [2:0] o, input logic [13:0] im);
      r = {$random(seed), $random(seed)};
      {acc_in, aux_in, ptr_hi, ptr_mid, ptr_lo, direct_word, memreg_sel} = r[33:0];
      ram_mode = 2'(r[39:38] % 3);
      step = s;
      op = o;
      imm = im;
      nx = ep + 14'h1;
      ta = {2'h0, im[3:0], acc_in, aux_in};
      if (s)
         case (o)
            3'h1: ep = im;
            3'h2: ep = {nx[13:8], im[7:0]};
            3'h3: ep = {8'h00, im[5:0]};
            3'h4: ep = ta;
            default: ep = nx;
         endcase
      @(negedge clk_sys);
      `CHK(pc, ep)
      `CHK(ram_addr, exp_ram())
      `CHK(page, ep[12:8])
      `CHK(rom_addr, (s && o == 3'h5) ? ta : ep)
      if (s && o == 3'h5)
      begin
         step = 1'b0;
         d = ta[9:0] ^ {ta[13:10], 6'h2a};
         @(negedge clk_sys);
         `CHK(acc_we, d[8])
         @(negedge clk_sys);
         if (d[8]) {ea, eb} = d[7:0];
         if (d[9]) {e1, e2} = d[7:0];
         `CHK({acc_out, aux_out, port_one_output, port_two_output}, {ea, eb, e1, e2})
         `CHK(pc, ep)
      end
   endtask
   // Expected RAM address; the memory registers sit in the window starting at 10'h040.
   function automatic logic [9:0] exp_ram();
      case (ram_mode)
         2'h0: return {ptr_hi[1:0], ptr_mid, ptr_lo};
         2'h1: return direct_word;
         default: return {6'h04, memreg_sel};
      endcase
   endfunction
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Corner cases first: a jump from the last word of a page, then a counter wrap.
   initial
   begin
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      run(1'b1, 3'h1, 14'h12ff);
      run(1'b1, 3'h2, 14'h0033);
      run(1'b1, 3'h1, 14'h3fff);
      run(1'b1, 3'h0, 14'h0000);
      repeat (600)
      begin
         r2 = $random(seed);
         run(r2[3], 3'(r2[2:0] % 6), r2[31:18]);
      end
      report_and_stop;
   end
endmodule
`default_nettype wire
